// >>> hdl/overload_pkg.sv
// Notes on behaviour
// R1: The first warning asserts while the measured current is above the first threshold.
// R2: A warning deasserts while the measured current is below its own threshold.
// R3: A second, independent warning compares the same current against a second threshold.
// R4: Comparison stays active both while motoring and while braking regeneratively.
// R5: Each asserted warning drives its assigned output low.
// R6: Warning one goes to terminals selecting code 03, warning two to those selecting code 26.
// R7: Both thresholds hold 100% of rated current after reset until the user programs them.
// R8: On exact equality with a threshold a warning keeps its previous state.
package overload_pkg;

    // Current and thresholds are in tenths of a percent of rated current.
    localparam int unsigned CUR_W         = 12;
    localparam logic [11:0] THRESH_RESET  = 12'h3e8;
    localparam int unsigned TERM_COUNT    = 8;
    localparam int unsigned SEL_W         = 6;
    localparam logic [5:0]  SEL_WARN_ONE  = 6'h03;
    localparam logic [5:0]  SEL_WARN_TWO  = 6'h1a;

    // One threshold write from the operator panel or parameter store.
    typedef struct packed {
        logic             wr_one;
        logic             wr_two;
        logic [CUR_W-1:0] value;
    } thresh_wr_s;

endpackage : overload_pkg

// >>> hdl/overload_compare.sv
`timescale 1ns/1ps
module overload_compare
(
    input  wire logic                            sys_clk,
    input  wire logic                            rst,
    input  wire logic [overload_pkg::CUR_W-1:0]  current,
    input  wire logic [overload_pkg::CUR_W-1:0]  threshold,
    output logic                                 warn_r
);

    // Strict comparisons both ways leave equality as a hold, which avoids chatter.
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            warn_r <= 1'b0;
        end
        else if (current > threshold)
        begin
            warn_r <= 1'b1; // R1
        end
        else if (current < threshold)
        begin
            warn_r <= 1'b0; // R2
        end
        else
        begin
            warn_r <= warn_r; // R8
        end
    end

endmodule : overload_compare

// >>> hdl/overload_advance_warning.sv
`timescale 1ns/1ps
module overload_advance_warning
(
    input  wire logic                                                   sys_clk,
    input  wire logic                                                   rst,
    input  wire logic [overload_pkg::CUR_W-1:0]                         current_mag,
    input  wire overload_pkg::thresh_wr_s                               thresh_wr,
    input  wire logic [overload_pkg::TERM_COUNT*overload_pkg::SEL_W-1:0] term_sel,
    output logic                                                        overload_warning_one,
    output logic                                                        overload_warning_two,
    output logic [overload_pkg::TERM_COUNT-1:0]                         term_out_n,
    output logic [overload_pkg::CUR_W-1:0]                              overload_threshold_one,
    output logic [overload_pkg::CUR_W-1:0]                              overload_threshold_two
);

    // Warning indices into the per-warning storage; index 0 feeds warning one.
    localparam int unsigned WARN_COUNT = 2;
    localparam int unsigned IDX_ONE    = 0;
    localparam int unsigned IDX_TWO    = 1;

    // Threshold words, one flip-flop word per warning, addressed by warning index.
    logic [overload_pkg::CUR_W-1:0]      thresh_r [WARN_COUNT];

    // Write strobe decoded per warning.
    logic [WARN_COUNT-1:0]               load_hit;

    // Comparator results, one edge after the current sample.
    wire logic [WARN_COUNT-1:0]          cmp_warn;

    // Registered warning levels, two edges after the current sample.
    logic [WARN_COUNT-1:0]               warn_lvl_r;

    // Per-terminal matches against the two warning codes.
    logic [overload_pkg::TERM_COUNT-1:0] match_one;
    logic [overload_pkg::TERM_COUNT-1:0] match_two;

    // Picks the strobe that belongs to one warning.
    // Both strobes may be high together, and then both words load the same value.
    function automatic logic strobe_for
    (
        input overload_pkg::thresh_wr_s wr,
        input int unsigned              idx
    );
        logic hit;
        hit = 1'b0;
        if (idx == IDX_ONE)
        begin
            hit = wr.wr_one;
        end
        else if (idx == IDX_TWO)
        begin
            hit = wr.wr_two;
        end
        return hit;
    endfunction : strobe_for

    // True when one terminal's selection field holds the given function code.
    function automatic logic sel_match
    (
        input logic [overload_pkg::TERM_COUNT*overload_pkg::SEL_W-1:0] sel_all,
        input int unsigned                                              term,
        input logic [overload_pkg::SEL_W-1:0]                           code
    );
        logic [overload_pkg::SEL_W-1:0] field;
        field = sel_all[term*overload_pkg::SEL_W +: overload_pkg::SEL_W];
        return field == code;
    endfunction : sel_match

    // Write decode is combinational, so a write lands at the same edge for both words.
    always_comb
    begin
        for (int unsigned w = 0; w < WARN_COUNT; w++)
        begin
            load_hit[w] = strobe_for(thresh_wr, w);
        end
    end

    // Decoding each terminal's code once keeps the output registers to a plain select.
    always_comb
    begin
        for (int unsigned t = 0; t < overload_pkg::TERM_COUNT; t++)
        begin
            match_one[t] = sel_match(term_sel, t, overload_pkg::SEL_WARN_ONE); // R6
            match_two[t] = sel_match(term_sel, t, overload_pkg::SEL_WARN_TWO); // R6
        end
    end

    // Each warning owns its threshold, comparator and level; only the current is shared.
    generate
        for (genvar w = 0; w < WARN_COUNT; w++)
        begin : g_warn
            // Threshold word; reset loads rated current until the user writes a new level.
            always_ff @(posedge sys_clk)
            begin
                if (rst)
                begin
                    thresh_r[w] <= overload_pkg::THRESH_RESET; // R7
                end
                else if (load_hit[w])
                begin
                    thresh_r[w] <= thresh_wr.value;
                end
            end

            // The input is a magnitude, so regeneration compares the same as motoring.
            overload_compare u_cmp
            (
                .sys_clk   (sys_clk),
                .rst       (rst),
                .current   (current_mag), // R4
                .threshold (thresh_r[w]),
                .warn_r    (cmp_warn[w]) // R1 R3
            );

            // Level register keeps the observation output in step with the terminals.
            always_ff @(posedge sys_clk)
            begin
                if (rst)
                begin
                    warn_lvl_r[w] <= 1'b0;
                end
                else
                begin
                    warn_lvl_r[w] <= cmp_warn[w];
                end
            end
        end
    endgenerate

    // Terminal routing; a terminal with any other code stays high, which is off.
    generate
        for (genvar t = 0; t < overload_pkg::TERM_COUNT; t++)
        begin : g_term
            always_ff @(posedge sys_clk)
            begin
                if (rst)
                begin
                    term_out_n[t] <= 1'b1;
                end
                else if (match_one[t])
                begin
                    term_out_n[t] <= ~cmp_warn[IDX_ONE]; // R5 R6
                end
                else if (match_two[t])
                begin
                    term_out_n[t] <= ~cmp_warn[IDX_TWO]; // R5 R6
                end
                else
                begin
                    term_out_n[t] <= 1'b1;
                end
            end
        end
    endgenerate

    // Outputs are direct copies of the flip-flops above, with no logic in between.
    assign overload_threshold_one = thresh_r[IDX_ONE];
    assign overload_threshold_two = thresh_r[IDX_TWO];
    assign overload_warning_one   = warn_lvl_r[IDX_ONE]; // R1
    assign overload_warning_two   = warn_lvl_r[IDX_TWO]; // R3

endmodule : overload_advance_warning

// >>> test/overload_assertions.sv
`timescale 1ns/1ps
module overload_chk
(
    input wire logic                     sys_clk,
    input wire logic                     rst,
    input wire logic [11:0]              current_mag,
    input wire overload_pkg::thresh_wr_s thresh_wr,
    input wire logic [47:0]              term_sel,
    input wire logic                     overload_warning_one,
    input wire logic                     overload_warning_two,
    input wire logic [7:0]               term_out_n,
    input wire logic [11:0]              overload_threshold_one,
    input wire logic [11:0]              overload_threshold_two
);
    // Short aliases keep each property on one line.
    wire logic [11:0] cur = current_mag;
    wire logic [11:0] th1 = overload_threshold_one;
    wire logic [11:0] th2 = overload_threshold_two;
    wire logic w1 = overload_warning_one;
    wire logic w2 = overload_warning_two;
    // Three steady samples span the whole pipeline with one edge to spare, so one extra stage would still pass.
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    a_one_on: assert property ((cur > th1) [*3] |=> w1) else $error("one not set");
    a_one_off: assert property ((cur < th1) [*3] |=> !w1) else $error("one not clear");
    a_two_on: assert property ((cur > th2) [*3] |=> w2) else $error("two not set");
    a_two_off: assert property ((cur < th2) [*3] |=> !w2) else $error("two not clear");
    a_tie_hold: assert property ((cur == th1) [*3] |=> $stable(w1)) else $error("moved");
    a_tie_two: assert property ((cur == th2) [*3] |=> $stable(w2))
        else $error("two moved");
    a_term_low: assert property
        ($stable(term_sel) && term_sel[5:0] == 6'h03 |-> term_out_n[0] == !w1)
        else $error("terminal wrong");
    a_term_two: assert property
        ($stable(term_sel) && term_sel[11:6] == 6'h1a |-> term_out_n[1] == !w2)
        else $error("terminal two wrong");
    a_reset_thr: assert property
        ($fell(rst) |-> th1 == 12'h3e8 && th2 == 12'h3e8) else $error("reset level");
    a_thr_load: assert property
        (thresh_wr.wr_two |=> th2 == $past(thresh_wr.value)) else $error("no load");
endmodule : overload_chk

bind overload_advance_warning overload_chk overload_chk_i (.*);

// >>> test/tb.sv
`timescale 1ns/1ps
module tb;
    logic                     sys_clk = 0;
    logic                     rst = 1;
    logic                     look = 0;
    logic [11:0]              current_mag = 0;
    overload_pkg::thresh_wr_s thresh_wr = '0;
    logic [47:0]              term_sel = 0;
    logic                     overload_warning_one, overload_warning_two, e1 = 0, e2 = 0;
    logic [7:0]               term_out_n;
    logic [11:0]              overload_threshold_one, overload_threshold_two;
    logic [11:0]              h1 = 12'h3e8, h2 = 12'h3e8;
    logic [33:0]              exp_q[$], ex;
    int                       errors = 0, n_checks = 0, cyc = 0;
    integer                   seed = 32'hfa07985b;
    localparam logic [47:0]   SEL_DIR = {6'h03, 30'h0, 6'h1a, 6'h03};
    wire logic [33:0]         got = {overload_warning_one, overload_warning_two, term_out_n,
                                     overload_threshold_one, overload_threshold_two};
`define CHECK(g, e) begin n_checks++; if ((g) !== (e)) begin errors++; \
    $display("CHECK FAILED %0t got %h exp %h", $time, g, e); end end
    overload_advance_warning overload_advance_warning_i (.*);
    always #20 sys_clk = ~sys_clk;
    // Equality keeps the last state, so the model must remember it too.
    task automatic step(input logic [11:0] c, input logic [47:0] s);
        logic [7:0] tv;
        current_mag = c;
        term_sel = s;
        e1 = c > h1 ? 1'b1 : c < h1 ? 1'b0 : e1;
        e2 = c > h2 ? 1'b1 : c < h2 ? 1'b0 : e2;
        for (int t = 0; t < 8; t++)
            tv[t] = !(s[6*t+:6] == 6'h03 && e1 || s[6*t+:6] == 6'h1a && e2);
        exp_q.push_back({e1, e2, tv, h1, h2});
        repeat (4) @(negedge sys_clk);
        look = 1;
        @(negedge sys_clk);
        look = 0;
    endtask : step
    task automatic wr(input logic a, input logic b, input logic [11:0] v);
        thresh_wr = '{a, b, v};
        if (a) h1 = v;
        if (b) h2 = v;
        @(negedge sys_clk);
        thresh_wr = '0;
        @(negedge sys_clk);
    endtask : wr
    task automatic end_of_test();
        $display("errors=%0d n_checks=%0d", errors, n_checks);
        if (errors == 0 && n_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : end_of_test
    // The watcher pairs each settled result with the oldest note; a hang ends the run.
    always @(posedge sys_clk)
    begin
        cyc++;
        if (cyc > 1000)
        begin
            errors++;
            end_of_test();
        end
        else if (look)
        begin
            ex = exp_q.pop_front();
            `CHECK(got, ex)
        end
    end
    // Directed edges and exact ties at both thresholds, random currents, then a second reset.
    initial
    begin
        repeat (6) @(negedge sys_clk);
        rst = 0;
        for (int i = 11; i >= 0; i--)
        begin
            if (i == 7)
            begin
                wr(1, 0, 12'h1f4);
                wr(0, 1, 12'h5dc);
            end
            step(i > 7 ? 12'h3e9 - 12'(i[0]) * 12'h2 : i > 3 ? 12'h640 - 12'(i) * 12'h8c : 12'h3e8,
                 SEL_DIR);
        end
        step(12'h1f4, SEL_DIR);
        step(12'h1f3, SEL_DIR);
        step(12'h1f4, SEL_DIR);
        step(12'h5dc, SEL_DIR);
        step(12'h5dd, SEL_DIR);
        step(12'h5dc, SEL_DIR);
        repeat (30)
            step(12'($random(seed)), {16'($random(seed)), 32'($random(seed))});
        rst = 1;
        repeat (2) @(negedge sys_clk);
        rst = 0;
        h1 = 12'h3e8;
        h2 = 12'h3e8;
        e1 = 0;
        e2 = 0;
        step(12'h3e8, SEL_DIR);
        end_of_test();
    end
endmodule : tb
